// ### shared/pad_mux_map.svh
// register offsets, field positions, reset values and pin masks
`ifndef PAD_MUX_MAP_SVH
`define PAD_MUX_MAP_SVH

// byte offsets, one 32-bit word each
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_FSEL0 8'h08
`define ADDR_OE0 8'h14
`define ADDR_IE0 8'h20
`define ADDR_PADS0 8'h2C
`define ADDR_STRIDE 8'h04

// control fields
`define CTRL_POLICY_BIT 0
`define CTRL_RUN_BIT 1

// reset values
`define CTRL_RST 2'h0
`define FSEL_RST 32'h00000000
`define OE_RST 16'h0000
`define IE_RST 16'h0000

// pins whose selected function uses a pull-down when idle
`define PD_A_F0 16'h0018
`define PD_A_F1 16'h4060
`define PD_A_F3 16'hF00C
`define PD_B_F0 16'h8000
`define PD_B_F2 16'h0370

// pins whose selected function is the removable card interface
`define MSI_A_F1 16'h0100

`endif

// ### shared/pad_mux_pkg.sv
// types shared by the pad multiplexer and its users
package pad_mux_pkg;

    // one bit per pin for ports a, b and c
    typedef logic [2:0][15:0] pin3_t;

    // per port, per function (0..3), per pin
    typedef logic [2:0][3:0][15:0] fnv_t;

    // pad phase, one-hot
    typedef enum logic [2:0] {
        ST_RST = 3'b001,
        ST_BOOT = 3'b010,
        ST_RUN = 3'b100
    } phase_t;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } av_req_t;

    // static memory controller outputs on port a
    typedef struct packed {
        logic [1:0] byte_en;
        logic [1:0] bank_sel;
        logic [8:1] addr;
        logic read_strobe;
        logic write_strobe;
        logic out_enable;
        logic drive;
    } smc_ctl_t;

endpackage

// ### core/pad_mux.sv
// port pad multiplexer with pull control and register slave
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pad_mux_map.svh"

module pad_mux #(
    parameter int PC_PINS = 15
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire pad_mux_pkg::av_req_t av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    input wire pad_mux_pkg::pin3_t pad_in,
    output pad_mux_pkg::pin3_t pad_out,
    output pad_mux_pkg::pin3_t pad_oe,
    output pad_mux_pkg::pin3_t pull_up,
    output pad_mux_pkg::pin3_t pull_down,
    input wire pad_mux_pkg::fnv_t fn_out,
    input wire pad_mux_pkg::fnv_t fn_oe,
    output pad_mux_pkg::fnv_t fn_in,
    output pad_mux_pkg::pin3_t tap_in,
    input wire pad_mux_pkg::smc_ctl_t smc_ctl,
    input wire logic [15:0] smc_dout,
    input wire logic smc_doe,
    output logic [15:0] smc_din,
    output logic smc_ready,
    input wire logic [7:0] ppi_dout,
    input wire logic [7:0] ppi_doe,
    output logic [7:0] ppi_din,
    output pad_mux_pkg::phase_t phase
);
    import pad_mux_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (PC_PINS < 1 || PC_PINS > 16) begin : g_bad_pc
        $error("PC_PINS must be 1 to 16");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // bit reversal of a byte
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = v[7 - k];
        end
        return r;
    endfunction

    // pins that exist on a port
    function automatic logic [15:0] pmask(input int p);
        logic [15:0] m;
        m = 16'hFFFF;
        if (p == 2) begin
            m = 16'(({16'h0000, 16'hFFFF} << PC_PINS) >> 16);
        end
        return m;
    endfunction

    // pull-down pins per port and function
    function automatic logic [15:0] pd_mask(input int p,
                                            input logic [1:0] f);
        logic [15:0] m;
        m = 16'h0000;
        case ({p[1:0], f})
            4'h0: m = `PD_A_F0;
            4'h1: m = `PD_A_F1;
            4'h3: m = `PD_A_F3;
            4'h4: m = `PD_B_F0;
            4'h6: m = `PD_B_F2;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

    // card interface pins per port and function
    function automatic logic [15:0] msi_mask(input int p,
                                             input logic [1:0] f);
        logic [15:0] m;
        m = 16'h0000;
        if (p == 0 && f == 2'h1) begin
            m = `MSI_A_F1;
        end
        return m;
    endfunction

    // byte-lane merge of a write
    function automatic logic [31:0] merge32(input logic [31:0] o,
                                            input logic [31:0] n,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                r[8*k +: 8] = n[8*k +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0] ctrl_reg; // policy and run bits
    logic [2:0][31:0] fsel_reg; // two select bits per pin
    pin3_t oe_reg; // software output enables
    pin3_t ie_reg; // software input enables
    logic ack_reg; // bus answer cycle
    phase_t phase_reg; // pad phase
    phase_t phase_next;
    logic [31:0] rd_next; // read data to register
    fnv_t eo; // function outputs after remap
    fnv_t eoe; // function enables after remap
    pin3_t out_next, oe_next, pu_next, pd_next;
    fnv_t in_next;
    logic wr_go; // write commits this edge
    logic [5:0] widx; // word index of request

    assign widx = av_req.address[7:2];
    assign wr_go = av_req.write & ack_reg;
    assign phase = phase_reg;

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------

    // wait while the answer is not yet ready
    assign av_waitrequest = (av_req.read | av_req.write) & ~ack_reg;

    // answer flag, high one cycle per request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (av_req.read | av_req.write) & ~ack_reg;
        end
    end

    // read mux, unmapped reads return zero
    always_comb begin
        rd_next = 32'h00000000;
        if (widx == `ADDR_CTRL >> 2) begin
            rd_next = {30'h0, ctrl_reg};
        end else if (widx == `ADDR_STATUS >> 2) begin
            rd_next = {29'h0, phase_reg};
        end
        for (int p = 0; p < 3; p++) begin
            if (widx == 6'((`ADDR_FSEL0 + p * `ADDR_STRIDE) >> 2)) begin
                rd_next = fsel_reg[p];
            end
            if (widx == 6'((`ADDR_OE0 + p * `ADDR_STRIDE) >> 2)) begin
                rd_next = {16'h0, oe_reg[p]};
            end
            if (widx == 6'((`ADDR_IE0 + p * `ADDR_STRIDE) >> 2)) begin
                rd_next = {16'h0, ie_reg[p]};
            end
            if (widx == 6'((`ADDR_PADS0 + p * `ADDR_STRIDE) >> 2)) begin
                rd_next = {16'h0, pad_in[p] & pmask(p)};
            end
        end
    end

    // read data stands in the answer cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            av_readdata <= 32'h00000000;
        end else if (av_req.read & ~ack_reg) begin
            av_readdata <= rd_next;
        end
    end

    // control register; run bit stays set until reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg <= `CTRL_RST;
        end else if (wr_go && widx == `ADDR_CTRL >> 2
                     && av_req.byteenable[0]) begin
            ctrl_reg[`CTRL_POLICY_BIT] <=
                av_req.writedata[`CTRL_POLICY_BIT];
            ctrl_reg[`CTRL_RUN_BIT] <= ctrl_reg[`CTRL_RUN_BIT]
                | av_req.writedata[`CTRL_RUN_BIT];
        end
    end

    // per-port select and enable registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int p = 0; p < 3; p++) begin
                fsel_reg[p] <= `FSEL_RST;
                oe_reg[p] <= `OE_RST;
                ie_reg[p] <= `IE_RST;
            end
        end else if (wr_go) begin
            for (int p = 0; p < 3; p++) begin
                if (widx == 6'((`ADDR_FSEL0 + p * `ADDR_STRIDE) >> 2))
                begin
                    fsel_reg[p] <= merge32(fsel_reg[p],
                        av_req.writedata, av_req.byteenable);
                end
                if (widx == 6'((`ADDR_OE0 + p * `ADDR_STRIDE) >> 2))
                begin
                    oe_reg[p] <= 16'(merge32({16'h0, oe_reg[p]},
                        av_req.writedata, av_req.byteenable));
                end
                if (widx == 6'((`ADDR_IE0 + p * `ADDR_STRIDE) >> 2))
                begin
                    ie_reg[p] <= 16'(merge32({16'h0, ie_reg[p]},
                        av_req.writedata, av_req.byteenable));
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pad phase
    // ------------------------------------------------------------

    // reset, then boot pull-ups, then software control
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            ST_RST: phase_next = ST_BOOT;
            ST_BOOT: begin
                if (ctrl_reg[`CTRL_RUN_BIT]) begin
                    phase_next = ST_RUN;
                end
            end
            ST_RUN: phase_next = ST_RUN;
            default: phase_next = ST_RST;
        endcase
    end

    // phase register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_reg <= ST_RST;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // ------------------------------------------------------------
    // function remap for the named buses
    // ------------------------------------------------------------
    always_comb begin
        eo = fn_out;
        eoe = fn_oe;
        // port a function 3: memory control, pin 3 is ready input
        eo[0][3] = {smc_ctl.bank_sel[0], smc_ctl.write_strobe,
                    smc_ctl.read_strobe, smc_ctl.out_enable,
                    smc_ctl.addr[4], smc_ctl.addr[3],
                    smc_ctl.addr[2], smc_ctl.addr[1],
                    smc_ctl.addr[5], smc_ctl.addr[6],
                    smc_ctl.addr[7], smc_ctl.addr[8], 1'b0,
                    smc_ctl.bank_sel[1], smc_ctl.byte_en};
        eoe[0][3] = {16{smc_ctl.drive}} & 16'hFFF7;
        // port b function 3: memory data, low byte reversed
        eo[1][3] = {smc_dout[15:8], rev8(smc_dout[7:0])};
        eoe[1][3] = {16{smc_doe}};
        // port b function 0 low byte: parallel data reversed
        eo[1][0][7:0] = rev8(ppi_dout);
        eoe[1][0][7:0] = rev8(ppi_doe);
    end

    // ------------------------------------------------------------
    // pad drive and pull selection
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] f;
        logic [15:0] pd, removable_card_interface, mp;
        f = 2'h0;
        pd = 16'h0000;
        removable_card_interface = 16'h0000;
        mp = 16'h0000;
        out_next = '0;
        oe_next = '0;
        pu_next = '0;
        pd_next = '0;
        in_next = '0;
        for (int p = 0; p < 3; p++) begin
            mp = pmask(p);
            for (int i = 0; i < 16; i++) begin
                f = fsel_reg[p][2*i +: 2];
                pd = pd_mask(p, f);
                removable_card_interface = msi_mask(p, f);
                out_next[p][i] = eo[p][f][i];
                oe_next[p][i] = oe_reg[p][i] & eoe[p][f][i] & mp[i];
                in_next[p][f][i] = pad_in[p][i] & ie_reg[p][i] & mp[i];
                if (pd[i]) begin
                    pd_next[p][i] = ~oe_next[p][i];
                end else if (removable_card_interface[i]) begin
                    pu_next[p][i] = 1'b0;
                end else if (ctrl_reg[`CTRL_POLICY_BIT]) begin
                    pu_next[p][i] = ~oe_next[p][i] & mp[i];
                end else begin
                    pu_next[p][i] = ~oe_next[p][i]
                        & ~ie_reg[p][i] & mp[i];
                end
            end
            // before code runs: no drive, pull-ups on
            if (phase_next != ST_RUN) begin
                oe_next[p] = 16'h0000;
                pu_next[p] = pmask(p);
                pd_next[p] = 16'h0000;
                in_next[p] = '0;
            end
        end
    end

    // registered pad controls, all off while in reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pad_out <= '0;
            pad_oe <= '0;
            pull_up <= '0;
            pull_down <= '0;
        end else begin
            pad_out <= out_next;
            pad_oe <= oe_next;
            pull_up <= pu_next;
            pull_down <= pd_next;
        end
    end

    // registered function inputs and taps
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fn_in <= '0;
            tap_in <= '0;
        end else begin
            fn_in <= in_next;
            for (int p = 0; p < 3; p++) begin
                tap_in[p] <= pad_in[p] & pmask(p);
            end
        end
    end

    // registered named bus inputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            smc_din <= 16'h0000;
            smc_ready <= 1'b0;
            ppi_din <= 8'h00;
        end else begin
            smc_din <= {in_next[1][3][15:8],
                        rev8(in_next[1][3][7:0])};
            smc_ready <= in_next[0][3][3];
            ppi_din <= rev8(in_next[1][0][7:0]);
        end
    end

endmodule

// ### testbench/pad_mux_monitor.sv
// assertion checker for the pad multiplexer ports
`timescale 1ns/100ps
`include "pad_mux_map.svh"
module pad_mux_monitor #(
    parameter int PC_PINS = 15
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire pad_mux_pkg::av_req_t av_req,
    input wire logic av_waitrequest,
    input wire pad_mux_pkg::pin3_t pad_in,
    input wire pad_mux_pkg::pin3_t pad_oe,
    input wire pad_mux_pkg::pin3_t pull_up,
    input wire pad_mux_pkg::pin3_t pull_down,
    input wire pad_mux_pkg::pin3_t tap_in,
    input wire pad_mux_pkg::fnv_t fn_in,
    input wire pad_mux_pkg::phase_t phase
);
    import pad_mux_pkg::*;
    // ------------------------------------
    // masks of existing and pull-down pins
    // ------------------------------------
    localparam logic [15:0] PCM = 16'((32'h1 << PC_PINS) - 1);
    localparam pin3_t ALL = {PCM, 16'hFFFF, 16'hFFFF};
    localparam pin3_t PDM = {16'h0, `PD_B_F0 | `PD_B_F2,
        `PD_A_F0 | `PD_A_F1 | `PD_A_F3};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // accepted write that sets the run bit
    sequence run_write;
        av_req.write && !av_waitrequest && av_req.address[7:2] == 6'h0
            && av_req.byteenable[0] && av_req.writedata[`CTRL_RUN_BIT];
    endsequence
    // request in its wait cycle
    sequence req_wait;
        (av_req.read || av_req.write) && av_waitrequest;
    endsequence
    a_reset_float: assert property (disable iff (1'b0)
        !rst_b |=> pad_oe == '0 && pull_up == '0 && pull_down == '0)
        else $error("pads not floating in reset");
    a_boot_entry: assert property (
        $rose(rst_b) |=> phase == ST_BOOT && pull_up == ALL)
        else $error("boot pull-ups missing");
    a_prerun_quiet: assert property (
        phase != ST_RUN |-> pad_oe == '0 && pull_down == '0 && fn_in == '0)
        else $error("pads active before run");
    a_run_entry: assert property (run_write |-> ##2 phase == ST_RUN)
        else $error("run phase not entered");
    a_run_sticky: assert property (phase == ST_RUN |=> $stable(phase))
        else $error("run phase left");
    a_pull_exclusive: assert property (
        phase == ST_RUN |-> (pull_up & pad_oe) == '0
            && (pull_down & pad_oe) == '0 && (pull_up & pull_down) == '0)
        else $error("pull on a driven pad");
    a_pd_mapped: assert property ((pull_down & ~PDM) == '0)
        else $error("pull-down on unmapped pin");
    a_tap_follow: assert property (
        $past(rst_b) |-> ((tap_in ^ $past(pad_in)) & ALL) == '0)
        else $error("tap lost pad value");
    a_one_wait: assert property (req_wait |=> !av_waitrequest)
        else $error("wait longer than one cycle");
endmodule
bind pad_mux pad_mux_monitor #(.PC_PINS(PC_PINS)) i_mon (
    .clk(clk), .rst_b(rst_b), .av_req(av_req),
    .av_waitrequest(av_waitrequest), .pad_in(pad_in), .pad_oe(pad_oe),
    .pull_up(pull_up), .pull_down(pull_down), .tap_in(tap_in),
    .fn_in(fn_in), .phase(phase));

// ### testbench/pad_board.sv
// board model: drives released pads, resolves pulls and floating
`timescale 1ns/100ps
module pad_board (
    input wire logic clk,
    input wire pad_mux_pkg::pin3_t pad_out,
    input wire pad_mux_pkg::pin3_t pad_oe,
    input wire pad_mux_pkg::pin3_t pull_up,
    input wire pad_mux_pkg::pin3_t pull_down,
    input wire pad_mux_pkg::pin3_t drv_en,
    input wire pad_mux_pkg::pin3_t drv_val,
    output pad_mux_pkg::pin3_t pad_in
);
    import pad_mux_pkg::*;
    pin3_t last = '0; // level seen last cycle
    // floating pins toggle so a stale value never passes
    always_ff @(posedge clk) begin
        last <= pad_in;
    end
    // device drive first, then board, then pulls
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv_val)
        | (~pad_oe & ~drv_en & (pull_up | (~pull_down & ~last)));
endmodule

// ### testbench/pad_mux_tb_top.sv
// self-checking bench for the pad multiplexer
`timescale 1ns/100ps
`include "pad_mux_map.svh"
module pad_mux_tb_top;
    import pad_mux_pkg::*;
    localparam int PCP = 15; // port c pin count
    localparam logic [15:0] PCM = 16'((32'h1 << PCP) - 1);
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    av_req_t av_req = '0;
    logic [31:0] av_readdata;
    logic av_waitrequest;
    pin3_t pad_in, pad_out, pad_oe, pull_up, pull_down, tap_in;
    fnv_t fn_out = '0;
    fnv_t fn_oe = '1; // every function may drive
    fnv_t fn_in;
    smc_ctl_t smc_ctl = '0;
    logic [15:0] smc_dout = '0;
    logic [15:0] smc_din;
    logic smc_doe = 1'b1;
    logic smc_ready;
    logic [7:0] ppi_dout = '0;
    logic [7:0] ppi_doe = '1;
    logic [7:0] ppi_din;
    phase_t phase;
    pin3_t drv_en = '1;
    pin3_t drv_val = '0;
    int seed = 32'h9706;
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] exp_q[$]; // expected read data
    logic [31:0] fs[3];
    logic [15:0] oe[3];
    logic [15:0] ie[3];
    initial forever #50 clk = ~clk;
    pad_mux #(.PC_PINS(PCP)) i_dut (.clk(clk), .rst_b(rst_b),
        .av_req(av_req), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up),
        .pull_down(pull_down), .fn_out(fn_out), .fn_oe(fn_oe),
        .fn_in(fn_in), .tap_in(tap_in), .smc_ctl(smc_ctl),
        .smc_dout(smc_dout), .smc_doe(smc_doe), .smc_din(smc_din),
        .smc_ready(smc_ready), .ppi_dout(ppi_dout), .ppi_doe(ppi_doe),
        .ppi_din(ppi_din), .phase(phase));
    pad_board i_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_up(pull_up), .pull_down(pull_down), .drv_en(drv_en),
        .drv_val(drv_val), .pad_in(pad_in));
    // ------------------------------------
    // helpers
    // ------------------------------------
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // pins whose select field equals f
    function automatic logic [15:0] sel(input logic [31:0] s, input int f);
        for (int i = 0; i < 16; i++) sel[i] = s[2*i+:2] == f;
    endfunction
    function automatic logic [7:0] rev8(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev8[i] = x[7-i];
    endfunction
    // memory control order on port a, ready pin undriven
    function automatic logic [15:0] amap(input smc_ctl_t c);
        return {c.bank_sel[0], c.write_strobe, c.read_strobe,
            c.out_enable, c.addr[4:1], c.addr[5], c.addr[6], c.addr[7],
            c.addr[8], 1'b0, c.bank_sel[1], c.byte_en};
    endfunction
    // effective drive: software enable, ready pin never driven
    function automatic logic [15:0] eo_of(input int p);
        return oe[p] & ~(p == 0 ? sel(fs[0], 3) & 16'h0008 : 16'h0)
            & (p == 2 ? PCM : 16'hFFFF);
    endfunction
    // one avalon transfer, held until waitrequest is low
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        av_req <= '{!w, w, a, d, 4'hF};
        do begin
            @(posedge clk);
            n++;
        end while (av_waitrequest !== 1'b0 && n < 20);
        if (av_waitrequest !== 1'b0) mismatches++;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // read results compared as they appear
    always @(posedge clk) begin
        if (av_req.read && av_waitrequest === 1'b0)
            chk(av_readdata, exp_q.pop_front());
    end
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk(phase, ST_RST);
        chk(pad_oe | pull_up | pull_down, '0);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(negedge clk);
        chk(phase, ST_BOOT);
        chk(pull_up, {PCM, 16'hFFFF, 16'hFFFF});
        $display("test reset done");
    endtask
    // compare enables and pulls against the pull rules; pad_out for port c, port a functions 0-2, port b functions 1-2 and the named buses
    task automatic check_pads(input int pol);
        logic [15:0] eo, pd, removable_card_interface, mp, v, w;
        for (int p = 0; p < 3; p++) begin
            eo = eo_of(p);
            mp = p == 2 ? PCM : 16'hFFFF;
            pd = p == 0 ? sel(fs[0], 0) & `PD_A_F0 | sel(fs[0], 1) & `PD_A_F1
                | sel(fs[0], 3) & `PD_A_F3 : p == 1 ? sel(fs[1], 0)
                & `PD_B_F0 | sel(fs[1], 2) & `PD_B_F2 : 16'h0;
            removable_card_interface = p == 0 ? sel(fs[0], 1) & `MSI_A_F1 : 16'h0;
            chk(pad_oe[p], eo);
            chk(pull_up[p], ~eo & (pol ? mp : ~ie[p]) & ~pd & ~removable_card_interface & mp);
            chk(pull_down[p], ~eo & pd);
            chk(tap_in[p] & mp, pad_in[p] & mp);
            for (int f = 0; f < 4; f++) begin
                v = sel(fs[p], f) & mp;
                chk(fn_in[p][f] & mp, v & ie[p] & pad_in[p]);
                if (p == 2 || f == 1 || f == 2 || (p == 0 && f == 0))
                    chk(pad_out[p] & v & eo, fn_out[p][f] & v & eo);
            end
        end
        v = eo_of(0);
        w = pad_in[1] & ie[1];
        if (fs[0] == '1) begin
            chk(pad_out[0] & v, amap(smc_ctl) & v);
            chk(smc_ready, pad_in[0][3] & ie[0][3]);
        end
        v = eo_of(1);
        if (fs[1] == '1) begin
            chk(pad_out[1] & v, {smc_dout[15:8], rev8(smc_dout[7:0])} & v);
            chk(smc_din, {w[15:8], rev8(w[7:0])});
        end
        if (fs[1] == '0) begin
            chk(pad_out[1][7:0] & v[7:0], rev8(ppi_dout) & v[7:0]);
            chk(ppi_din, rev8(w[7:0]));
        end
    endtask
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        do_reset();
        rd(`ADDR_CTRL, 32'h0);
        rd(`ADDR_STATUS, {29'h0, ST_BOOT});
        wr(8'h40, $random(seed));
        rd(8'h40, 32'h0);
        for (int pol = 0; pol < 2; pol++) begin
            wr(`ADDR_CTRL, {30'h0, 1'b1, pol[0]});
            rd(`ADDR_STATUS, {29'h0, ST_RUN});
            for (int k = 0; k < 5; k++) begin
                for (int p = 0; p < 3; p++) begin
                    fs[p] = k == 0 ? 32'h5555_5555 : k == 1 ? '1 :
                        k == 2 ? '0 : $random(seed);
                    oe[p] = k == 0 ? 16'h0 : 16'($random(seed));
                    ie[p] = 16'($random(seed));
                    wr(`ADDR_FSEL0 + 8'(4 * p), fs[p]);
                    wr(`ADDR_OE0 + 8'(4 * p), {16'h0, oe[p]});
                    wr(`ADDR_IE0 + 8'(4 * p), {16'h0, ie[p]});
                    rd(`ADDR_FSEL0 + 8'(4 * p), fs[p]);
                    for (int f = 0; f < 4; f++)
                        fn_out[p][f] <= 16'($random(seed));
                end
                smc_ctl <= 16'($random(seed)) | 16'h0001;
                smc_dout <= 16'($random(seed));
                ppi_dout <= 8'($random(seed));
                drv_val <= 48'({$random(seed), $random(seed)});
                drv_en <= ~{eo_of(2), eo_of(1), eo_of(0)};
                repeat (3) @(negedge clk);
                check_pads(pol);
                rd(`ADDR_PADS0, {16'h0000, pad_in[0]});
            end
            $display("test policy %0d done", pol);
        end
        wr(`ADDR_PADS0, 32'hFFFF_FFFF);
        do_reset();
        rd(`ADDR_CTRL, 32'h0);
        $display("test second reset done");
        wrap_up();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
